// ===== include/mps_pkg.sv
// constants for the modulo pointer selection block
// assumes an AXI4-Lite master and a datapath on the same clock
package mps_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 16;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_X_START = 8'h04;
  localparam logic [7:0] OFS_X_END = 8'h08;
  localparam logic [7:0] OFS_Y_START = 8'h0C;
  localparam logic [7:0] OFS_Y_END = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_X_LEN = 8'h18;
  localparam logic [7:0] OFS_Y_LEN = 8'h1C;
  localparam int unsigned X_SEL_LSB = 0;
  localparam int unsigned Y_SEL_LSB = 4;
  localparam int unsigned X_EN_BIT = 15;
  localparam int unsigned Y_EN_BIT = 14;
  localparam logic [3:0] SEL_NONE = 4'hF;
  localparam logic [15:0] CTRL_RST = 16'h00FF;
  localparam logic [15:0] CTRL_MASK = 16'hC0FF;
  localparam logic [15:0] BOUND_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== include/mps_space_if.sv
// carries one address space's wrap settings between modules
// assumes the top drives settings and a length unit drives results
`timescale 1ns/100ps
`default_nettype none
interface mps_space_if;
  logic wrap_on;
  logic [3:0] sel;
  logic [15:0] buf_start;
  logic [15:0] buf_end;
  logic [15:0] len_words;
  logic pow2;
  logic order_ok;
  modport cfg (output wrap_on, sel, buf_start, buf_end,
    input len_words, pow2, order_ok);
  modport len (input buf_start, buf_end, output len_words, pow2, order_ok);
  modport unit (input wrap_on, sel, buf_start, buf_end, pow2, order_ok);
endinterface
`default_nettype wire

// ===== rtl/mps_len_calc.sv
// buffer length and shape from the two bounds
// assumes bounds are byte addresses of word items
`timescale 1ns/100ps
`default_nettype none
module mps_len_calc
  import mps_pkg::*;
(
  mps_space_if.len sp
);
  logic [16:0] diff;
  logic [15:0] words;
  assign diff = {1'b0, sp.buf_end} - {1'b0, sp.buf_start};
  assign words = diff[16:1] + 16'h0001;
  assign sp.len_words = words;
  assign sp.order_ok = sp.buf_end >= sp.buf_start;
  assign sp.pow2 = (words & (words - 16'h0001)) == 16'h0000;
endmodule // mps_len_calc
`default_nettype wire

// ===== rtl/mps_top.sv
// modulo pointer selection: control registers and three generators
// assumes an AXI4-Lite master and an execution datapath on aclk
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module mps_top
  import mps_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic xr_valid,
  input wire logic [3:0] xr_ptr_num,
  input wire logic [15:0] xr_ptr,
  input wire logic [15:0] xr_step,
  output logic xr_addr_valid,
  output logic [15:0] xr_addr,
  output logic xr_wrapped,
  input wire logic xw_valid,
  input wire logic [3:0] xw_ptr_num,
  input wire logic [15:0] xw_ptr,
  input wire logic [15:0] xw_step,
  output logic xw_addr_valid,
  output logic [15:0] xw_addr,
  output logic xw_wrapped,
  input wire logic y_valid,
  input wire logic [3:0] y_ptr_num,
  input wire logic [15:0] y_ptr,
  input wire logic [15:0] y_step,
  output logic y_addr_valid,
  output logic [15:0] y_addr,
  output logic y_wrapped
);
  mps_space_if x_sp ();
  mps_space_if y_sp ();

  logic [15:0] modulo_select_control;
  logic [15:0] x_buffer_start;
  logic [15:0] x_buffer_end;
  logic [15:0] y_buffer_start;
  logic [15:0] y_buffer_end;
  logic [15:0] next_modulo_select_control;
  logic [15:0] next_x_buffer_start;
  logic [15:0] next_x_buffer_end;
  logic [15:0] next_y_buffer_start;
  logic [15:0] next_y_buffer_end;

  logic aw_full;
  logic [7:0] aw_addr;
  logic w_full;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic next_aw_full;
  logic [7:0] next_aw_addr;
  logic next_w_full;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  logic [3:0] x_wrap_pointer_select;
  logic [3:0] y_wrap_pointer_select;
  logic x_wrap_enable;
  logic y_wrap_enable;
  logic do_write;
  logic [16:0] rd_word;
  logic [15:0] status;

  // control field extraction
  assign x_wrap_pointer_select = modulo_select_control[X_SEL_LSB +: 4];
  assign y_wrap_pointer_select = modulo_select_control[Y_SEL_LSB +: 4];
  assign x_wrap_enable = modulo_select_control[X_EN_BIT];
  assign y_wrap_enable = modulo_select_control[Y_EN_BIT];

  // space settings; selector 15 forces wrapping off
  assign x_sp.wrap_on = x_wrap_enable && (x_wrap_pointer_select != SEL_NONE);
  assign x_sp.sel = x_wrap_pointer_select;
  assign x_sp.buf_start = x_buffer_start;
  assign x_sp.buf_end = x_buffer_end;
  assign y_sp.wrap_on = y_wrap_enable && (y_wrap_pointer_select != SEL_NONE);
  assign y_sp.sel = y_wrap_pointer_select;
  assign y_sp.buf_start = y_buffer_start;
  assign y_sp.buf_end = y_buffer_end;

  mps_len_calc u_x_len (
    .sp (x_sp)
  );

  mps_len_calc u_y_len (
    .sp (y_sp)
  );

  // x read and x write generators share the x settings
  mps_wrap_unit #(.WORD_ONLY(1'b0)) u_xr (
    .aclk (aclk),
    .aresetn (aresetn),
    .sp (x_sp),
    .req_valid (xr_valid),
    .ptr_num (xr_ptr_num),
    .ptr (xr_ptr),
    .step (xr_step),
    .out_valid (xr_addr_valid),
    .out_addr (xr_addr),
    .wrapped (xr_wrapped)
  );

  mps_wrap_unit #(.WORD_ONLY(1'b0)) u_xw (
    .aclk (aclk),
    .aresetn (aresetn),
    .sp (x_sp),
    .req_valid (xw_valid),
    .ptr_num (xw_ptr_num),
    .ptr (xw_ptr),
    .step (xw_step),
    .out_valid (xw_addr_valid),
    .out_addr (xw_addr),
    .wrapped (xw_wrapped)
  );

  mps_wrap_unit #(.WORD_ONLY(1'b1)) u_y (
    .aclk (aclk),
    .aresetn (aresetn),
    .sp (y_sp),
    .req_valid (y_valid),
    .ptr_num (y_ptr_num),
    .ptr (y_ptr),
    .step (y_step),
    .out_valid (y_addr_valid),
    .out_addr (y_addr),
    .wrapped (y_wrapped)
  );

  // merges a 16-bit register with strobed write data
  function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = data[7:0];
    end
    if (strb[1]) begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction

  // true for any mapped word address
  function automatic logic is_mapped(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    return (w == OFS_CTRL) || (w == OFS_X_START) || (w == OFS_X_END) ||
      (w == OFS_Y_START) || (w == OFS_Y_END) || (w == OFS_STATUS) ||
      (w == OFS_X_LEN) || (w == OFS_Y_LEN);
  endfunction

  assign status = {10'h000, y_sp.order_ok, x_sp.order_ok, y_sp.pow2,
    x_sp.pow2, y_sp.wrap_on, x_sp.wrap_on};

  // read data for one word address
  always_comb begin
    rd_word = 17'h00000;
    unique case ({s_axi_araddr[7:2], 2'b00})
      OFS_CTRL: rd_word = {1'b1, modulo_select_control};
      OFS_X_START: rd_word = {1'b1, x_buffer_start};
      OFS_X_END: rd_word = {1'b1, x_buffer_end};
      OFS_Y_START: rd_word = {1'b1, y_buffer_start};
      OFS_Y_END: rd_word = {1'b1, y_buffer_end};
      OFS_STATUS: rd_word = {1'b1, status};
      OFS_X_LEN: rd_word = {1'b1, x_sp.len_words};
      OFS_Y_LEN: rd_word = {1'b1, y_sp.len_words};
      default: rd_word = 17'h00000;
    endcase
  end

  assign s_axi_awready = ~aw_full;
  assign s_axi_wready = ~w_full;
  assign s_axi_arready = ~rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  assign do_write = aw_full && w_full && !bvalid;

  // bus channels
  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full = w_full;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_awvalid && !aw_full) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rdata = {16'h0000, rd_word[15:0]};
      next_rresp = rd_word[16] ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // register writes
  always_comb begin
    next_modulo_select_control = modulo_select_control;
    next_x_buffer_start = x_buffer_start;
    next_x_buffer_end = x_buffer_end;
    next_y_buffer_start = y_buffer_start;
    next_y_buffer_end = y_buffer_end;
    if (do_write) begin
      unique case ({aw_addr[7:2], 2'b00})
        OFS_CTRL: next_modulo_select_control =
          merge16(modulo_select_control, w_data, w_strb) & CTRL_MASK;
        OFS_X_START: next_x_buffer_start = merge16(x_buffer_start, w_data, w_strb);
        OFS_X_END: next_x_buffer_end = merge16(x_buffer_end, w_data, w_strb);
        OFS_Y_START: next_y_buffer_start = merge16(y_buffer_start, w_data, w_strb);
        OFS_Y_END: next_y_buffer_end = merge16(y_buffer_end, w_data, w_strb);
        default: next_modulo_select_control = modulo_select_control;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
      w_full <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full <= next_w_full;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      modulo_select_control <= CTRL_RST;
      x_buffer_start <= BOUND_RST;
      x_buffer_end <= BOUND_RST;
      y_buffer_start <= BOUND_RST;
      y_buffer_end <= BOUND_RST;
    end else begin
      modulo_select_control <= next_modulo_select_control;
      x_buffer_start <= next_x_buffer_start;
      x_buffer_end <= next_x_buffer_end;
      y_buffer_start <= next_y_buffer_start;
      y_buffer_end <= next_y_buffer_end;
    end
  end
endmodule // mps_top
`default_nettype wire

// ===== rtl/mps_wrap_unit.sv
// one address generator: steps a pointer and wraps it in its buffer
// assumes one request per cycle at most, result one cycle later
`timescale 1ns/100ps
`default_nettype none
module mps_wrap_unit
  import mps_pkg::*;
#(
  parameter bit WORD_ONLY = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  mps_space_if.unit sp,
  input wire logic req_valid,
  input wire logic [3:0] ptr_num,
  input wire logic [15:0] ptr,
  input wire logic [15:0] step,
  output logic out_valid,
  output logic [15:0] out_addr,
  output logic wrapped
);
  logic selected;
  logic inc;
  logic over;
  logic under;
  logic signed [17:0] sum;
  logic next_valid;
  logic next_wrapped;
  logic [15:0] next_addr;

  always_comb begin
    selected = sp.wrap_on && sp.order_ok && (ptr_num == sp.sel);
    inc = ~step[15];
    sum = $signed({2'b00, ptr}) + $signed({{2{step[15]}}, step});
    over = inc && (sum > $signed({2'b00, sp.buf_end}));
    under = ~inc && (sum < $signed({2'b00, sp.buf_start}));
    next_valid = req_valid;
    next_wrapped = 1'b0;
    next_addr = out_addr;
    if (req_valid) begin
      next_addr = sum[15:0];
      if (selected && over) begin
        next_addr = sp.buf_start;
        next_wrapped = 1'b1;
      end else if (selected && under) begin
        next_addr = sp.buf_end;
        next_wrapped = 1'b1;
      end
      if (WORD_ONLY) begin
        next_addr[0] = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid <= 1'b0;
      out_addr <= 16'h0000;
      wrapped <= 1'b0;
    end else begin
      out_valid <= next_valid;
      out_addr <= next_addr;
      wrapped <= next_wrapped;
    end
  end
endmodule // mps_wrap_unit
`default_nettype wire

// ===== test/mps_checker.sv
// assertions on the generator ports of the pointer selection top
// assumes it is bound to mps_top and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module mps_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic xr_valid,
  input wire logic [3:0] xr_ptr_num,
  input wire logic [15:0] xr_ptr,
  input wire logic [15:0] xr_step,
  input wire logic xr_addr_valid,
  input wire logic [15:0] xr_addr,
  input wire logic xr_wrapped,
  input wire logic xw_valid,
  input wire logic [15:0] xw_ptr,
  input wire logic [15:0] xw_step,
  input wire logic xw_addr_valid,
  input wire logic [15:0] xw_addr,
  input wire logic xw_wrapped,
  input wire logic y_valid,
  input wire logic [3:0] y_ptr_num,
  input wire logic [15:0] y_ptr,
  input wire logic [15:0] y_step,
  input wire logic y_addr_valid,
  input wire logic [15:0] y_addr,
  input wire logic y_wrapped
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  xr_answer_a: assert property (xr_valid |=> xr_addr_valid)
    else $error("x read answer missing");
  xw_answer_a: assert property (xw_valid |=> xw_addr_valid)
    else $error("x write answer missing");
  y_answer_a: assert property (y_valid |=> y_addr_valid)
    else $error("y answer missing");
  y_even_a: assert property (y_addr_valid |-> !y_addr[0])
    else $error("y address odd");
  xr_plain_a: assert property (xr_valid ##1 !xr_wrapped |->
    xr_addr == $past(xr_ptr) + $past(xr_step)) else $error("x read sum wrong");
  xw_plain_a: assert property (xw_valid ##1 !xw_wrapped |->
    xw_addr == $past(xw_ptr) + $past(xw_step)) else $error("x write sum wrong");
  y_plain_a: assert property (y_valid ##1 !y_wrapped |->
    y_addr == (($past(y_ptr) + $past(y_step)) & 16'hFFFE)) else $error("y sum wrong");
  x_none_a: assert property (xr_valid && xr_ptr_num == 4'hF |=> !xr_wrapped)
    else $error("x wrapped on pointer 15");
  y_none_a: assert property (y_valid && y_ptr_num == 4'hF |=> !y_wrapped)
    else $error("y wrapped on pointer 15");
endmodule // mps_checker
bind mps_top mps_checker mps_checker_inst (.*);
`default_nettype wire

// ===== test/mps_dp_model.sv
// execution datapath model: issues pointer step requests
// assumes one request at a time, driven just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module mps_dp_model (
  input wire logic aclk,
  output logic [2:0] req_v,
  output logic [3:0] num,
  output logic [15:0] ptr,
  output logic [15:0] step
);
  initial begin
    req_v = 3'h0;
    num = 4'h0;
    ptr = 16'h0000;
    step = 16'h0000;
  end
  // one cycle request on generator s
  task automatic req(input logic [1:0] s, input logic [3:0] n, input logic [15:0] p, st);
    @(posedge aclk);
    req_v <= 3'h1 << s;
    num <= n;
    ptr <= p;
    step <= st;
    @(posedge aclk);
    req_v <= 3'h0;
    ptr <= ~p;
  endtask
endmodule // mps_dp_model
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the modulo pointer selection top
// assumes the checker is bound and the datapath model drives requests
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import mps_pkg::*;
  typedef struct {logic [1:0] s; logic [3:0] n; logic [15:0] p, st, ea; logic ew;} mps_row_s;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, xr_valid, xw_valid, y_valid, xr_addr_valid, xw_addr_valid;
  logic y_addr_valid, xr_wrapped, xw_wrapped, y_wrapped;
  logic [3:0] xr_ptr_num, xw_ptr_num, y_ptr_num, pn;
  logic [15:0] xr_ptr, xw_ptr, y_ptr, xr_step, xw_step, y_step, pp, ps;
  logic [15:0] xr_addr, xw_addr, y_addr;
  logic [2:0] rv;
  int err_count = 0, n_tests = 0, cyc = 0;
  mps_row_s rows [8] = '{
    '{2'd0, 4'h3, 16'h101E, 16'h0002, 16'h1000, 1'b1},
    '{2'd0, 4'h3, 16'h1000, 16'hFFFE, 16'h101E, 1'b1},
    '{2'd0, 4'h4, 16'h101E, 16'h0002, 16'h1020, 1'b0},
    '{2'd1, 4'h3, 16'h101C, 16'h0002, 16'h101E, 1'b0},
    '{2'd1, 4'h3, 16'h101E, 16'h0004, 16'h1000, 1'b1},
    '{2'd2, 4'h5, 16'h200E, 16'h0002, 16'h2000, 1'b1},
    '{2'd2, 4'h5, 16'h2000, 16'hFFFE, 16'h200E, 1'b1},
    '{2'd2, 4'h3, 16'h2003, 16'h0002, 16'h2004, 1'b0}};
  assign {y_valid, xw_valid, xr_valid} = rv;
  assign {xr_ptr_num, xw_ptr_num, y_ptr_num} = {3{pn}};
  assign {xr_ptr, xw_ptr, y_ptr} = {3{pp}};
  assign {xr_step, xw_step, y_step} = {3{ps}};
  mps_top mps_top_inst (.*);
  mps_dp_model mps_dp_model_inst (.aclk(aclk), .req_v(rv), .num(pn), .ptr(pp), .step(ps));
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
    wr_resp = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'b0;
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
  endtask
  task automatic gen(input logic [1:0] s, input logic [3:0] n, input logic [15:0] p, st, ea,
      input logic ew);
    logic [17:0] got;
    mps_dp_model_inst.req(s, n, p, st);
    #1;
    got = (s == 0) ? {xr_addr_valid, xr_wrapped, xr_addr} :
      (s == 1) ? {xw_addr_valid, xw_wrapped, xw_addr} : {y_addr_valid, y_wrapped, y_addr};
    chk({14'h0, got}, {14'h0, 1'b1, ew, ea}, "generator result");
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_CTRL);
    chk(rd_data, 32'h000000FF, "control reset");
    rd(OFS_X_START);
    chk(rd_data, 32'h0, "start reset");
    wr(OFS_CTRL, 32'h0000C053);
    chk({30'h0, wr_resp}, {30'h0, RESP_OKAY}, "write response");
    wr(OFS_X_START, 32'h1000);
    wr(OFS_X_END, 32'h101E);
    wr(OFS_Y_START, 32'h2000);
    wr(OFS_Y_END, 32'h200E);
    rd(OFS_CTRL);
    chk(rd_data, 32'h0000C053, "control");
    rd(OFS_Y_END);
    chk(rd_data, 32'h200E, "y end");
    rd(OFS_X_LEN);
    chk(rd_data, 32'h10, "x length");
    rd(OFS_Y_LEN);
    chk(rd_data, 32'h8, "y length");
    rd(OFS_STATUS);
    chk(rd_data, 32'h3F, "status");
    rd(8'h20);
    chk({30'h0, rd_resp}, {30'h0, RESP_SLVERR}, "unmapped");
    wr(8'h24, 32'h1);
    chk({30'h0, wr_resp}, {30'h0, RESP_SLVERR}, "unmapped write");
    $display("register tests done");
    foreach (rows[i]) gen(rows[i].s, rows[i].n, rows[i].p, rows[i].st, rows[i].ea, rows[i].ew);
    $display("row tests done");
    wr(OFS_CTRL, 32'h00004053);
    gen(2'd0, 4'h3, 16'h101E, 16'h0002, 16'h1020, 1'b0);
    wr(OFS_CTRL, 32'h0000C05F);
    gen(2'd0, 4'hF, 16'h101E, 16'h0002, 16'h1020, 1'b0);
    gen(2'd1, 4'hF, 16'h101E, 16'h0002, 16'h1020, 1'b0);
    wr(OFS_CTRL, 32'h0000C0F3);
    gen(2'd2, 4'hF, 16'h200E, 16'h0002, 16'h2010, 1'b0);
    wr(OFS_CTRL, 32'h00008053);
    gen(2'd2, 4'h5, 16'h200E, 16'h0002, 16'h2010, 1'b0);
    $display("mode tests done");
    s_axi_wstrb <= 4'h1;
    wr(OFS_X_END, 32'h0000FFFF);
    s_axi_wstrb <= 4'hF;
    rd(OFS_X_END);
    chk(rd_data, 32'h10FF, "low byte strobe");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk({15'h0, xr_addr_valid, xr_addr}, 32'h0, "generator after reset");
    rd(OFS_CTRL);
    chk(rd_data, 32'h000000FF, "control after reset");
    rd(OFS_X_END);
    chk(rd_data, 32'h0, "end after reset");
    $display("reset tests done");
    test_done();
  end
endmodule // tb_top
`default_nettype wire
